/* logic/status_flag_output_mux.v */
`timescale 1ns/1ps
`include "status_flag_mux_regs.vh"

module status_flag_output_mux #(
    parameter NUM_PINS = 6,
    parameter SAMPLE_W = 24
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // control port register access
    input wire [`ADDR_W-1:0] reg_addr,
    input wire [`DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    output reg [`DATA_W-1:0] reg_rdata,
    // receiver status sources
    input wire validity_bit,
    input wire user_bit,
    input wire chan_status_bit,
    input wire parity_bit,
    input wire subframe_clock,
    input wire block_start_marker,
    input wire unlock_flag,
    input wire chan_status_update,
    input wire invalid_flag,
    input wire zero_detect_flag,
    input wire nonpcm_flag,
    input wire copy_inhibit_flag,
    input wire deemphasis_flag,
    input wire transmission_error_flag,
    // flag events, mask and error register
    input wire [`NUM_FLAGS-1:0] flag_update,
    input wire [`NUM_FLAGS-1:0] flag_mask,
    input wire [`NUM_FLAGS-1:0] error_clear,
    output reg [`NUM_FLAGS-1:0] error_flags,
    output reg int_n,
    // receiver sample path
    input wire [SAMPLE_W-1:0] rx_sample_in,
    input wire rx_sample_strobe,
    output reg [SAMPLE_W-1:0] rx_sample_out,
    output reg rx_sample_out_strobe,
    output wire fill_active,
    // general purpose pins
    input wire [NUM_PINS-1:0] pin_in,
    output wire [NUM_PINS-1:0] pin_out,
    output wire [NUM_PINS-1:0] pin_oe,
    // pin-based receiver inputs
    output wire [NUM_PINS-1:0] rx_pin_input_en,
    output wire [NUM_PINS-1:0] rx_pin_comparator_en,
    output wire [NUM_PINS-1:0] rx_pin_data
);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    reg [3:0] pin_one_source_sel_reg;
    reg [3:0] pin_two_source_sel_reg;
    reg [3:0] pin_three_source_sel_reg;
    reg [3:0] pin_four_source_sel_reg;
    reg [3:0] pin_five_source_sel_reg;
    reg [3:0] pin_six_source_sel_reg;
    reg error_fill_select_reg;
    reg invalid_autohandle_disable_reg;

    wire wr_first;
    wire wr_second;
    wire wr_third;

    // write decode
    assign wr_first = reg_wr && (reg_addr == `ADDR_SELECT_FIRST);
    assign wr_second = reg_wr && (reg_addr == `ADDR_SELECT_SECOND);
    assign wr_third = reg_wr && (reg_addr == `ADDR_SELECT_THIRD);

    // RQ7 reset select defaults
    // RQ9 write takes effect at once
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_one_source_sel_reg <= `RST_PIN_ONE_SEL;
            pin_two_source_sel_reg <= `RST_PIN_TWO_SEL;
            pin_three_source_sel_reg <= `RST_PIN_THREE_SEL;
            pin_four_source_sel_reg <= `RST_PIN_FOUR_SEL;
            pin_five_source_sel_reg <= `RST_PIN_FIVE_SEL;
            pin_six_source_sel_reg <= `RST_PIN_SIX_SEL;
            error_fill_select_reg <= `RST_FILL;
            invalid_autohandle_disable_reg <= `RST_AUTOHANDLE;
        end else begin
            if (wr_first) begin
                pin_one_source_sel_reg <= reg_wdata[`FLD_LOW_SEL_LSB +: 4];
                pin_two_source_sel_reg <= reg_wdata[`FLD_HIGH_SEL_LSB +: 4];
                error_fill_select_reg <= reg_wdata[`FLD_FILL_BIT];
            end
            if (wr_second) begin
                pin_three_source_sel_reg <= reg_wdata[`FLD_LOW_SEL_LSB +: 4];
                pin_four_source_sel_reg <= reg_wdata[`FLD_HIGH_SEL_LSB +: 4];
                invalid_autohandle_disable_reg <= reg_wdata[`FLD_AUTOHANDLE_BIT];
            end
            if (wr_third) begin
                pin_five_source_sel_reg <= reg_wdata[`FLD_LOW_SEL_LSB +: 4];
                pin_six_source_sel_reg <= reg_wdata[`FLD_HIGH_SEL_LSB +: 4];
            end
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    reg [`DATA_W-1:0] rdata_next;

    // read mux, unmapped addresses read zero
    always @* begin
        rdata_next = {`DATA_W{1'b0}};
        case (reg_addr)
            `ADDR_SELECT_FIRST: begin
                rdata_next = {error_fill_select_reg, pin_two_source_sel_reg,
                              pin_one_source_sel_reg};
            end
            `ADDR_SELECT_SECOND: begin
                rdata_next = {invalid_autohandle_disable_reg, pin_four_source_sel_reg,
                              pin_three_source_sel_reg};
            end
            `ADDR_SELECT_THIRD: begin
                rdata_next = {1'b0, pin_six_source_sel_reg, pin_five_source_sel_reg};
            end
            default: begin
                rdata_next = {`DATA_W{1'b0}};
            end
        endcase
    end

    // registered read data
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= {`DATA_W{1'b0}};
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // error register and interrupt
    // ------------------------------------------------------------
    wire [`NUM_FLAGS-1:0] live_events;

    // RQ8 masked flags stay silent
    assign live_events = flag_update & ~flag_mask;

    // sticky error bits, a new event wins over a clear
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            error_flags <= {`NUM_FLAGS{1'b0}};
        end else begin
            error_flags <= (error_flags & ~error_clear) | live_events;
        end
    end

    // RQ8 interrupt pulse gating
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~(|live_events);
        end
    end

    // ------------------------------------------------------------
    // receiver fill handling
    // ------------------------------------------------------------
    wire tx_error_fill;
    wire invalid_fill;
    reg [SAMPLE_W-1:0] last_good_reg;

    // error flag that is masked forces a fill
    assign tx_error_fill = transmission_error_flag & flag_mask[`FLAG_IDX_TX_ERROR];
    // RQ6 invalid auto handling switch
    assign invalid_fill = invalid_flag & flag_mask[`FLAG_IDX_INVALID] &
                          ~invalid_autohandle_disable_reg;
    assign fill_active = tx_error_fill | invalid_fill;

    // keep the newest clean sample
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            last_good_reg <= {SAMPLE_W{1'b0}};
        end else if (rx_sample_strobe && !fill_active) begin
            last_good_reg <= rx_sample_in;
        end
    end

    // output sample, replaced while filling
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_sample_out <= {SAMPLE_W{1'b0}};
            rx_sample_out_strobe <= 1'b0;
        end else begin
            rx_sample_out_strobe <= rx_sample_strobe;
            if (rx_sample_strobe) begin
                if (!fill_active) begin
                    rx_sample_out <= rx_sample_in;
                end else if (error_fill_select_reg) begin
                    // RQ5 zero fill
                    rx_sample_out <= {SAMPLE_W{1'b0}};
                end else begin
                    // RQ4 repeat last valid
                    rx_sample_out <= last_good_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    wire [`NUM_SOURCES-1:0] sources;
    wire [4*NUM_PINS-1:0] sel_bus;

    // RQ1 source vector in code order
    assign sources = {deemphasis_flag, copy_inhibit_flag, nonpcm_flag, zero_detect_flag,
                      invalid_flag, chan_status_update, unlock_flag, block_start_marker,
                      subframe_clock, parity_bit, chan_status_bit, user_bit,
                      validity_bit, int_n};

    assign sel_bus = {pin_six_source_sel_reg, pin_five_source_sel_reg,
                      pin_four_source_sel_reg, pin_three_source_sel_reg,
                      pin_two_source_sel_reg, pin_one_source_sel_reg};

    // one router per pin, inputs only on pins three to five
    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i = i + 1) begin : g_pin
            flag_pin_router #(
                .CAN_INPUT((i >= 2) && (i <= 4))
            ) u_router (
                .clock(clock),
                .rstn(rstn),
                .source_sel(sel_bus[4*i +: 4]),
                .sources(sources),
                .pin_in(pin_in[i]),
                .pin_out(pin_out[i]),
                .pin_oe(pin_oe[i]),
                .rx_input_en(rx_pin_input_en[i]),
                .rx_comparator_en(rx_pin_comparator_en[i]),
                .rx_pin_data(rx_pin_data[i])
            );
        end
    endgenerate

endmodule

/* logic/status_flag_mux_regs.vh */
// Behaviour
// RQ1 - Each 4-bit pin select code picks one source: 0 interrupt, 1-4 V/U/C/P, 5 subframe clock, 6 block start, 7-13 unlock, update, invalid, zero, nonpcm_flag, copy, de-emphasis.
// RQ2 - Code 1110 turns the third, fourth or fifth pin into a receiver input through the CMOS buffer.
// RQ3 - Code 1111 turns the third, fourth or fifth pin into a receiver input through the AC-coupled comparator path.
// RQ4 - With fill mode 0, a masked error or invalid flag that sets replaces output data with the last valid sample.
// RQ5 - With fill mode 1, a masked error or invalid flag that sets replaces output data with zeros.
// RQ6 - The invalid auto-handling control at 0 applies error handling on the invalid flag and at 1 disables it.
// RQ7 - After reset pins two to six select codes 0001, 0010, 0011, 0100 and 0101.
// RQ8 - A masked flag neither updates the error register nor pulses the interrupt; mask 0 leaves it active.
// RQ9 - Each pin follows its selected source at all times and a select write takes effect with no handshake; pin_out is registered, one clock behind.
`ifndef STATUS_FLAG_MUX_REGS_VH
`define STATUS_FLAG_MUX_REGS_VH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_W 7
`define DATA_W 9
`define ADDR_SELECT_FIRST 7'h26
`define ADDR_SELECT_SECOND 7'h27
`define ADDR_SELECT_THIRD 7'h28

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FLD_LOW_SEL_LSB 0
`define FLD_HIGH_SEL_LSB 4
`define FLD_FILL_BIT 8
`define FLD_AUTOHANDLE_BIT 8

// ------------------------------------------------------------
// reset values of the select, fill and auto-handling fields
// ------------------------------------------------------------
`define RST_PIN_ONE_SEL 4'h0
`define RST_PIN_TWO_SEL 4'h1
`define RST_PIN_THREE_SEL 4'h2
`define RST_PIN_FOUR_SEL 4'h3
`define RST_PIN_FIVE_SEL 4'h4
`define RST_PIN_SIX_SEL 4'h5
`define RST_FILL 1'h0
`define RST_AUTOHANDLE 1'h0

// ------------------------------------------------------------
// select codes
// ------------------------------------------------------------
`define SEL_INT_N 4'h0
`define SEL_LAST_SOURCE 4'hD
`define SEL_RX_CMOS 4'hE
`define SEL_RX_COMPARATOR 4'hF
`define NUM_SOURCES 14

// ------------------------------------------------------------
// flag indices in the mask and error vectors
// ------------------------------------------------------------
`define NUM_FLAGS 9
`define FLAG_IDX_INVALID 1
`define FLAG_IDX_TX_ERROR 2

`endif

/* logic/flag_pin_router.v */
`timescale 1ns/1ps
`include "status_flag_mux_regs.vh"

module flag_pin_router #(
    parameter CAN_INPUT = 0
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // selection and sources
    input wire [3:0] source_sel,
    input wire [`NUM_SOURCES-1:0] sources,
    // pin
    input wire pin_in,
    output reg pin_out,
    output wire pin_oe,
    // receiver input tap
    output wire rx_input_en,
    output wire rx_comparator_en,
    output wire rx_pin_data
);

    wire is_input_code;

    // input codes honoured only where the pin may be an input
    assign is_input_code = (source_sel == `SEL_RX_CMOS) || (source_sel == `SEL_RX_COMPARATOR);
    // RQ2 cmos input conversion
    assign rx_input_en = (CAN_INPUT != 0) && is_input_code;
    // RQ3 comparator input path
    assign rx_comparator_en = rx_input_en && (source_sel == `SEL_RX_COMPARATOR);
    assign rx_pin_data = rx_input_en ? pin_in : 1'b0;
    assign pin_oe = ~rx_input_en;

    // RQ1 source code mapping
    // RQ9 continuous source drive
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_out <= 1'b1;
        end else if (is_input_code) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= sources[source_sel];
        end
    end

endmodule

/* test/pin_monitor_model.sv */
`timescale 1ns/1ps
// ----------------
// external pin logic
// ----------------
module pin_monitor_model (
    // clock and pins
    input logic clock,
    input logic [5:0] pin_out,
    input logic [5:0] pin_oe,
    output logic [5:0] pin_in
);
    logic [5:0] pat = 6'h15;
    // released pins carry a toggling stream
    always @(posedge clock) pat <= ~pat;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pat);
endmodule

/* test/flag_mux_checker.sv */
`timescale 1ns/1ps
module flag_mux_checker #(parameter NUM_PINS = 6, parameter SAMPLE_W = 24) (
    // clock and reset
    input logic clock, rstn,
    // flags
    input logic transmission_error_flag, invalid_flag, int_n, fill_active,
    input logic [8:0] flag_update, flag_mask, error_clear, error_flags,
    // samples
    input logic [SAMPLE_W-1:0] rx_sample_in, rx_sample_out,
    input logic rx_sample_strobe, rx_sample_out_strobe,
    // pins
    input logic [NUM_PINS-1:0] pin_in, pin_oe, rx_pin_input_en,
    input logic [NUM_PINS-1:0] rx_pin_comparator_en, rx_pin_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_int_pulse: assert property ((flag_update & ~flag_mask) != 0 |=> !int_n)
        else $error("int_n pulse missing");
    a_int_quiet: assert property ((flag_update & ~flag_mask) == 0 |=> int_n)
        else $error("int_n pulse unexpected");
    a_err_set: assert property (1'b1 |=>
        (error_flags & $past(flag_update & ~flag_mask)) == $past(flag_update & ~flag_mask))
        else $error("error bit not set");
    a_err_hold: assert property ((flag_update & ~flag_mask) == 0 && error_clear == 0
        |=> $stable(error_flags)) else $error("error bits changed");
    a_sample_pass: assert property (rx_sample_strobe && !fill_active |=>
        rx_sample_out_strobe && rx_sample_out == $past(rx_sample_in))
        else $error("clean sample lost");
    a_fill_trans: assert property (transmission_error_flag && flag_mask[2] |-> fill_active)
        else $error("fill not active");
    a_fill_idle: assert property (!(transmission_error_flag && flag_mask[2])
        && !(invalid_flag && flag_mask[1]) |-> !fill_active) else $error("fill spurious");
    a_convert_pins: assert property ((rx_pin_input_en & 6'h23) == 0)
        else $error("pin converted wrongly");
    a_comp_subset: assert property ((rx_pin_comparator_en & ~rx_pin_input_en) == 0)
        else $error("comparator without input");
    a_rx_gate: assert property (rx_pin_data == (pin_in & rx_pin_input_en))
        else $error("rx pin data wrong");
    a_oe_release: assert property (pin_oe == ~rx_pin_input_en)
        else $error("pin enable wrong");
endmodule
bind status_flag_output_mux flag_mux_checker #(.NUM_PINS(NUM_PINS), .SAMPLE_W(SAMPLE_W)) u_chk (
    .clock(clock), .rstn(rstn), .transmission_error_flag(transmission_error_flag),
    .invalid_flag(invalid_flag), .int_n(int_n), .fill_active(fill_active),
    .flag_update(flag_update), .flag_mask(flag_mask), .error_clear(error_clear),
    .error_flags(error_flags), .rx_sample_in(rx_sample_in), .rx_sample_out(rx_sample_out),
    .rx_sample_strobe(rx_sample_strobe), .rx_sample_out_strobe(rx_sample_out_strobe),
    .pin_in(pin_in), .pin_oe(pin_oe), .rx_pin_input_en(rx_pin_input_en),
    .rx_pin_comparator_en(rx_pin_comparator_en), .rx_pin_data(rx_pin_data));

/* test/status_flag_output_mux_tb.sv */
`timescale 1ns/1ps
module status_flag_output_mux_tb;
    logic clock = 0, rstn = 0, reg_wr = 0, tx_err = 0, strobe = 0;
    logic [6:0] reg_addr = 0;
    logic [8:0] reg_wdata = 0, reg_rdata, upd = 0, mask = 0, clr = 0, error_flags;
    logic [12:0] src = 0;
    logic [23:0] smp_in = 0, smp_out;
    logic int_n, fill_active;
    logic [5:0] pin_in, pin_out, pin_oe, in_en, cmp_en, pin_data;
    wire v, u, c, p, sf, bs, ul, cu, inv, zf, na, cp, de;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    assign {de, cp, na, zf, inv, cu, ul, bs, sf, p, c, u, v} = src;
    always #10 clock = ~clock;
    status_flag_output_mux u_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .validity_bit(v),
        .user_bit(u), .chan_status_bit(c), .parity_bit(p), .subframe_clock(sf),
        .block_start_marker(bs), .unlock_flag(ul), .chan_status_update(cu),
        .invalid_flag(inv), .zero_detect_flag(zf), .nonpcm_flag(na),
        .copy_inhibit_flag(cp), .deemphasis_flag(de), .transmission_error_flag(tx_err),
        .flag_update(upd), .flag_mask(mask), .error_clear(clr), .error_flags(error_flags),
        .int_n(int_n), .rx_sample_in(smp_in), .rx_sample_strobe(strobe),
        .rx_sample_out(smp_out), .rx_sample_out_strobe(), .fill_active(fill_active),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .rx_pin_input_en(in_en),
        .rx_pin_comparator_en(cmp_en), .rx_pin_data(pin_data));
    pin_monitor_model u_pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in));
    // ----------------
    // bench tasks
    // ----------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        @(posedge clock);
        reg_addr <= a;
        @(posedge clock);
        @(negedge clock);
        chk(reg_rdata, exp);
    endtask
    task automatic ev(input logic [8:0] e, input logic [8:0] m);
        @(posedge clock);
        upd <= e;
        mask <= m;
        @(posedge clock);
        upd <= 9'h000;
        @(negedge clock);
    endtask
    task automatic smp(input logic [23:0] d, input logic [23:0] exp);
        @(posedge clock);
        smp_in <= d;
        strobe <= 1'b1;
        @(posedge clock);
        strobe <= 1'b0;
        @(negedge clock);
        chk(smp_out, exp);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up;
        end
    end
    // ----------------
    // test sequence
    // ----------------
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rd(7'h26, 9'h010); // defaults
        rd(7'h27, 9'h032); // defaults
        rd(7'h28, 9'h054); // defaults
        wr(7'h25, 9'h1FF);
        rd(7'h25, 9'h000); // unmapped
        wr(7'h28, 9'h1AB);
        rd(7'h28, 9'h0AB); // top bit reads 0
        $display("registers done");
        for (int k = 1; k < 14; k++) begin
            wr(7'h26, {5'h00, k[3:0]});
            src <= 13'h0001 << (k - 1);
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk(pin_out[1:0], 2'b11); // source and interrupt
        end
        src <= 13'h0000;
        $display("routing done");
        wr(7'h26, 9'h0EE);
        wr(7'h27, 9'h0FE);
        wr(7'h28, 9'h0EE);
        repeat (2) begin
            @(negedge clock);
            chk(in_en, 6'h1C); // only middle pins convert
            chk(cmp_en, 6'h08); // comparator path
            chk(pin_oe, 6'h23); // converted pins released
            chk(pin_out & 6'h23, 6'h00); // refused codes drive 0
            chk(pin_data, pin_in & 6'h1C); // receiver sees the pin
        end
        $display("conversion done");
        ev(9'h001, 9'h000);
        chk({int_n, error_flags}, 10'h001); // unmasked event
        @(negedge clock);
        chk(int_n, 1'b1); // single pulse
        ev(9'h004, 9'h004);
        chk({int_n, error_flags}, 10'h201); // masked event
        @(posedge clock);
        clr <= 9'h001;
        @(posedge clock);
        clr <= 9'h000;
        @(negedge clock);
        chk(error_flags, 9'h000); // cleared
        $display("flags done");
        wr(7'h26, 9'h010);
        wr(7'h27, 9'h032);
        smp(24'h123456, 24'h123456); // clean sample
        @(posedge clock);
        mask <= 9'h006;
        tx_err <= 1'b1;
        smp(24'hABCDEF, 24'h123456); // last valid sample
        wr(7'h26, 9'h110);
        smp(24'h111111, 24'h000000); // zero fill
        @(posedge clock);
        tx_err <= 1'b0;
        src <= 13'h0100;
        smp(24'h222222, 24'h000000); // invalid handled
        wr(7'h27, 9'h132);
        smp(24'h333333, 24'h333333); // handling disabled
        $display("fill done");
        wrap_up;
    end
endmodule
